// ==== rtl/tir_defines.svh ====
// tir_defines.svh: offsets-free constants of the tap instruction path
// assumes inclusion by bare name from the package and tir_top
`ifndef TIR_DEFINES_SVH
`define TIR_DEFINES_SVH

`define TIR_IR_LEN 7
`define TIR_IR_CAPTURE 7'h01
`define TIR_OP_BYPASS 7'h7f
`define TIR_OP_EXTEST 7'h00
`define TIR_OP_SAMPLE 7'h01
`define TIR_OP_IDCODE 7'h02
`define TIR_OP_CLAMP 7'h04
`define TIR_OP_HIGHZ 7'h08
`define TIR_ID_LEN 32
`define TIR_BSR_LEN 8
`define TIR_FIFO_DEPTH 32
`define TIR_SYNC_W 4

`endif

// ==== rtl/tir_pkg.sv ====
// tir_pkg: types shared by the tap instruction path
// assumes tir_defines.svh on the include path
`default_nettype none
`include "tir_defines.svh"

package tir_pkg;

  // gray codes along the usual walk of the tap controller
  typedef enum logic [3:0] {
    TIR_TLR = 4'h0,
    TIR_RTI = 4'h1,
    TIR_SELDR = 4'h3,
    TIR_CAPDR = 4'h2,
    TIR_SHDR = 4'h6,
    TIR_EX1DR = 4'h7,
    TIR_PDR = 4'h5,
    TIR_EX2DR = 4'h4,
    TIR_UPDR = 4'hc,
    TIR_SELIR = 4'hd,
    TIR_CAPIR = 4'hf,
    TIR_SHIR = 4'he,
    TIR_EX1IR = 4'ha,
    TIR_PIR = 4'hb,
    TIR_EX2IR = 4'h9,
    TIR_UPIR = 4'h8
  } tir_state_e;

  typedef enum logic [1:0] {
    TIR_DR_BYPASS = 2'h0,
    TIR_DR_IDCODE = 2'h1,
    TIR_DR_BSR = 2'h2
  } tir_dr_e;

  typedef struct packed {
    tir_state_e st;
    logic [`TIR_IR_LEN-1:0] ir_sr;
    logic [`TIR_IR_LEN-1:0] ir;
    logic [`TIR_BSR_LEN-1:0] bsr_sr;
    logic [`TIR_BSR_LEN-1:0] bsr_upd;
    logic [`TIR_ID_LEN-1:0] id_sr;
    logic byp;
    logic tdo;
    logic tdo_oe;
    logic tck_d;
  } tir_top_s;

endpackage

`default_nettype wire

// ==== rtl/tir_sync.sv ====
// tir_sync: two-stage synchroniser for the tap pins
// assumes asynchronous inputs, one sys_clk domain
`default_nettype none

module tir_sync #(
  parameter int W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  input wire logic [W-1:0] rst_val,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tir_sync_s;

  tir_sync_s r;
  tir_sync_s next_r;

  always_comb
  begin
    next_r = r;
    next_r.s1 = async_in;
    next_r.s2 = r.s1;
  end

  // reset constant comes from a tied port, so stages clear to zero and it is applied by an xor at the output
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  assign sync_out = r.s2 ^ rst_val;

endmodule

`default_nettype wire

// ==== rtl/tir_fifo.sv ====
// tir_fifo: synchronous fifo with valid/ready on both sides
// assumes one clock; depth a power of two
`default_nettype none

module tir_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } tir_fifo_s;

  tir_fifo_s r;
  tir_fifo_s next_r;
  logic full;
  logic empty;

  assign empty = (r.wr == r.rd);
  assign full = (r.wr[AW-1:0] == r.rd[AW-1:0]) && (r.wr[AW] != r.rd[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = r.mem[r.rd[AW-1:0]];

  always_comb
  begin
    next_r = r;
    if (in_valid && !full)
    begin
      next_r.mem[r.wr[AW-1:0]] = in_data;
      next_r.wr = r.wr + {{AW{1'b0}}, 1'b1};
    end
    if (out_ready && !empty)
      next_r.rd = r.rd + {{AW{1'b0}}, 1'b1};
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end

endmodule

`default_nettype wire

// ==== rtl/tir_top.sv ====
// tir_top: tap controller, instruction register and decode, public data registers
// assumes tap pins asynchronous to sys_clk, tck well below sys_clk/4
`default_nettype none
`include "tir_defines.svh"

module tir_top #(
  parameter logic [31:0] ID_CODE = 32'h0000_0001 // arbitrary value, lsb fixed at one
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [`TIR_BSR_LEN-1:0] core_out,
  output logic [`TIR_BSR_LEN-1:0] pin_out,
  output logic pin_hiz,
  input wire logic smp_valid,
  input wire logic [`TIR_BSR_LEN-1:0] smp_data,
  output logic smp_ready,
  output logic [`TIR_IR_LEN-1:0] ir_current,
  output logic test_reset
);

  tir_pkg::tir_top_s r;
  tir_pkg::tir_top_s next_r;
  logic [`TIR_SYNC_W-1:0] pins_s;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_s_n;
  logic rise;
  logic fall;
  logic fifo_valid;
  logic [`TIR_BSR_LEN-1:0] fifo_data;
  logic fifo_pop;
  tir_pkg::tir_dr_e dr_sel;

  // next tap state from tms
  function automatic tir_pkg::tir_state_e next_tap(input tir_pkg::tir_state_e s, input logic m);
    tir_pkg::tir_state_e n;
    n = tir_pkg::TIR_TLR;
    case (s)
      tir_pkg::TIR_TLR: n = m ? tir_pkg::TIR_TLR : tir_pkg::TIR_RTI;
      tir_pkg::TIR_RTI: n = m ? tir_pkg::TIR_SELDR : tir_pkg::TIR_RTI;
      tir_pkg::TIR_SELDR: n = m ? tir_pkg::TIR_SELIR : tir_pkg::TIR_CAPDR;
      tir_pkg::TIR_CAPDR: n = m ? tir_pkg::TIR_EX1DR : tir_pkg::TIR_SHDR;
      tir_pkg::TIR_SHDR: n = m ? tir_pkg::TIR_EX1DR : tir_pkg::TIR_SHDR;
      tir_pkg::TIR_EX1DR: n = m ? tir_pkg::TIR_UPDR : tir_pkg::TIR_PDR;
      tir_pkg::TIR_PDR: n = m ? tir_pkg::TIR_EX2DR : tir_pkg::TIR_PDR;
      tir_pkg::TIR_EX2DR: n = m ? tir_pkg::TIR_UPDR : tir_pkg::TIR_SHDR;
      tir_pkg::TIR_UPDR: n = m ? tir_pkg::TIR_SELDR : tir_pkg::TIR_RTI;
      tir_pkg::TIR_SELIR: n = m ? tir_pkg::TIR_TLR : tir_pkg::TIR_CAPIR;
      tir_pkg::TIR_CAPIR: n = m ? tir_pkg::TIR_EX1IR : tir_pkg::TIR_SHIR;
      tir_pkg::TIR_SHIR: n = m ? tir_pkg::TIR_EX1IR : tir_pkg::TIR_SHIR;
      tir_pkg::TIR_EX1IR: n = m ? tir_pkg::TIR_UPIR : tir_pkg::TIR_PIR;
      tir_pkg::TIR_PIR: n = m ? tir_pkg::TIR_EX2IR : tir_pkg::TIR_PIR;
      tir_pkg::TIR_EX2IR: n = m ? tir_pkg::TIR_UPIR : tir_pkg::TIR_SHIR;
      tir_pkg::TIR_UPIR: n = m ? tir_pkg::TIR_SELDR : tir_pkg::TIR_RTI;
      default: n = tir_pkg::TIR_TLR;
    endcase
    return n;
  endfunction

  // data register chosen by an opcode
  function automatic tir_pkg::tir_dr_e decode_dr(input logic [`TIR_IR_LEN-1:0] op);
    tir_pkg::tir_dr_e d;
    d = tir_pkg::TIR_DR_BYPASS;
    if (op == `TIR_OP_EXTEST || op == `TIR_OP_SAMPLE)
      d = tir_pkg::TIR_DR_BSR;
    else if (op == `TIR_OP_IDCODE)
      d = tir_pkg::TIR_DR_IDCODE;
    else if (op == `TIR_OP_BYPASS || op == `TIR_OP_CLAMP || op == `TIR_OP_HIGHZ)
      d = tir_pkg::TIR_DR_BYPASS;
    return d;
  endfunction

  // pins sampled by two flops; trst_n enters inverted so a cleared stage reads as released
  tir_sync #(
    .W(`TIR_SYNC_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({tck, tms, tdi, ~trst_n}),
    .rst_val(4'h1),
    .sync_out(pins_s)
  );

  assign tck_s = pins_s[3];
  assign tms_s = pins_s[2];
  assign tdi_s = pins_s[1];
  assign trst_s_n = pins_s[0];

  // boundary sample words queued by the core side
  tir_fifo #(
    .W(`TIR_BSR_LEN),
    .DEPTH(`TIR_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(smp_valid),
    .in_data(smp_data),
    .in_ready(smp_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  assign rise = tck_s && !r.tck_d;
  assign fall = !tck_s && r.tck_d;
  assign dr_sel = decode_dr(r.ir);
  // no pop while test reset blocks the capture that would use the word
  assign fifo_pop = rise && trst_s_n && r.st == tir_pkg::TIR_CAPDR && dr_sel == tir_pkg::TIR_DR_BSR
    && fifo_valid;

  always_comb
  begin
    next_r = r;
    next_r.tck_d = tck_s;
    if (!trst_s_n)
    begin
      next_r.st = tir_pkg::TIR_TLR;
      next_r.ir = `TIR_OP_IDCODE;
      next_r.tdo_oe = 1'b0;
    end
    else
    begin
      if (rise)
      begin
        case (r.st)
          tir_pkg::TIR_CAPIR: next_r.ir_sr = `TIR_IR_CAPTURE;
          tir_pkg::TIR_SHIR: next_r.ir_sr = {tdi_s, r.ir_sr[`TIR_IR_LEN-1:1]};
          tir_pkg::TIR_CAPDR:
          begin
            if (dr_sel == tir_pkg::TIR_DR_BYPASS)
              next_r.byp = 1'b0;
            else if (dr_sel == tir_pkg::TIR_DR_IDCODE)
              next_r.id_sr = ID_CODE;
            else
              next_r.bsr_sr = fifo_valid ? fifo_data : core_out;
          end
          tir_pkg::TIR_SHDR:
          begin
            if (dr_sel == tir_pkg::TIR_DR_BYPASS)
              next_r.byp = tdi_s;
            else if (dr_sel == tir_pkg::TIR_DR_IDCODE)
              next_r.id_sr = {tdi_s, r.id_sr[`TIR_ID_LEN-1:1]};
            else
              next_r.bsr_sr = {tdi_s, r.bsr_sr[`TIR_BSR_LEN-1:1]};
          end
          default: next_r.st = r.st;
        endcase
        next_r.st = next_tap(r.st, tms_s);
      end
      if (fall)
      begin
        case (r.st)
          tir_pkg::TIR_TLR: next_r.ir = `TIR_OP_IDCODE;
          tir_pkg::TIR_UPIR: next_r.ir = r.ir_sr;
          tir_pkg::TIR_UPDR:
          begin
            if (dr_sel == tir_pkg::TIR_DR_BSR)
              next_r.bsr_upd = r.bsr_sr;
          end
          default: next_r.ir = r.ir;
        endcase
        if (r.st == tir_pkg::TIR_SHIR)
        begin
          next_r.tdo = r.ir_sr[0];
          next_r.tdo_oe = 1'b1;
        end
        else if (r.st == tir_pkg::TIR_SHDR)
        begin
          if (dr_sel == tir_pkg::TIR_DR_BYPASS)
            next_r.tdo = r.byp;
          else if (dr_sel == tir_pkg::TIR_DR_IDCODE)
            next_r.tdo = r.id_sr[0];
          else
            next_r.tdo = r.bsr_sr[0];
          next_r.tdo_oe = 1'b1;
        end
        else
          next_r.tdo_oe = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.st <= tir_pkg::TIR_TLR;
      r.ir <= `TIR_OP_IDCODE;
    end
    else
      r <= next_r;
  end

  // cells drive pins under extest and clamp; highz floats the outputs
  always_comb
  begin
    if (r.ir == `TIR_OP_EXTEST || r.ir == `TIR_OP_CLAMP)
      pin_out = r.bsr_upd;
    else
      pin_out = core_out;
  end

  assign pin_hiz = (r.ir == `TIR_OP_HIGHZ);
  assign tdo = r.tdo;
  assign tdo_oe = r.tdo_oe;
  assign ir_current = r.ir;
  assign test_reset = (r.st == tir_pkg::TIR_TLR);

endmodule

`default_nettype wire

// ==== test/tir_top_sva.sv ====
// tir_top_sva: port assertions on tir_top
// assumes bind onto tir_top, all in the sys_clk domain
`default_nettype none
module tir_top_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [7:0] core_out,
  input wire logic [7:0] pin_out,
  input wire logic pin_hiz,
  input wire logic [6:0] ir_current,
  input wire logic test_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  tdo_on_fall_a: assert property ($changed(tdo) |-> !tck)
    else $error("tdo moved while tck high");
  ir_on_fall_a: assert property (disable iff (!rst_n || !trst_n) $changed(ir_current) |-> !tck)
    else $error("instruction moved while tck high");
  oe_in_shift_a: assert property ($rose(tdo_oe) |-> !tck && !test_reset)
    else $error("tdo enabled outside a shift fall");
  idcode_exit_a: assert property ($fell(test_reset) |-> ir_current == 7'h02)
    else $error("left reset without identity opcode");
  trst_hold_a: assert property (!trst_n [*5] |-> test_reset && !tdo_oe && ir_current == 7'h02)
    else $error("test reset not held");
  hiz_decode_a: assert property ($stable(ir_current) [*2] |-> pin_hiz == (ir_current == 7'h08))
    else $error("pin_hiz disagrees with opcode");
  pin_pass_a: assert property (($stable(ir_current) && !(ir_current inside {7'h00, 7'h04})) [*2]
    |-> pin_out == core_out) else $error("pins disturbed outside extest and clamp");
  pin_update_a: assert property ($changed(pin_out) && $stable(core_out) && $stable(ir_current)
    |-> ir_current inside {7'h00, 7'h04} && !tck) else $error("pins changed without boundary update");
  tlr_quiet_a: assert property (test_reset [*2] |-> !tdo_oe)
    else $error("tdo enabled in test-logic reset");
endmodule
bind tir_top tir_top_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n), .tck(tck), .trst_n(trst_n), .tdo(tdo),
  .tdo_oe(tdo_oe), .core_out(core_out), .pin_out(pin_out), .pin_hiz(pin_hiz), .ir_current(ir_current),
  .test_reset(test_reset));
`default_nettype wire

// ==== test/tir_jtag_model.sv ====
// tir_jtag_model: behavioural test controller on the tap pins
// assumes the first call starts just after a sys_clk rise; tck idles low
`default_nettype none
module tir_jtag_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // pins set on the fall, tdo taken just before the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #400;
    o = tdo;
    tck = 1'b1;
    #400;
    tck = 1'b0;
  endtask
  // tdi toggles outside shifts, it carries no meaning there
  task automatic walk(input int n, input logic [7:0] m);
    logic o;
    for (int i = 0; i < n; i++)
      step(m[i], i[0], o);
  endtask
  task automatic scan(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic o;
    dout = '0;
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
  endtask
  task automatic ir(input logic [6:0] op, output logic [31:0] cap);
    walk(4, 8'h03);
    scan(7, {25'h0, op}, cap);
    walk(2, 8'h01);
  endtask
  task automatic dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    walk(3, 8'h01);
    scan(n, din, dout);
    walk(2, 8'h01);
  endtask
endmodule
`default_nettype wire

// ==== test/tir_top_bench.sv ====
// tir_top_bench: self-checking bench of the tap instruction path
// assumes design, checker and jtag model compiled before it
`default_nettype none
module tir_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] ID = 32'h1a2b_3c4d; // arbitrary value, lsb one
  localparam logic [7:0] CORE = 8'h3c;
  logic sys_clk, rst_n, trst_n, smp_valid, tck, tms, tdi, tdo, tdo_oe, pin_hiz, smp_ready, test_reset;
  logic [7:0] pin_out, smp_data, core_out;
  logic [6:0] ir_current;
  logic [31:0] r;
  logic tdo_line;
  int err_count = 0;
  int tests_run = 0;
  tir_top #(.ID_CODE(ID)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .pin_out(pin_out), .pin_hiz(pin_hiz),
    .smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready), .ir_current(ir_current),
    .test_reset(test_reset));
  // released tdo reads inverted, so a late or missing enable shows as bad data
  assign tdo_line = tdo_oe ? tdo : ~tdo;
  tir_jtag_model jm (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_reset();
    logic [31:0] lo;
    chk("ir", 7'h02, ir_current);
    chk("tlr", 1'b1, test_reset);
    chk("oe", 1'b0, tdo_oe);
    jm.walk(6, 8'h1f);
    jm.dr(32, 32'h0, r);
    chk("id", ID, r);
    jm.walk(3, 8'h01);
    jm.scan(16, 32'h0, lo);
    jm.walk(4, 8'h04);
    jm.scan(16, 32'h0, r);
    jm.walk(2, 8'h01);
    chk("paused id", ID, {r[15:0], lo[15:0]});
    $display("t_reset done");
  endtask
  task automatic t_bypass();
    logic [6:0] ops [3] = '{7'h7f, 7'h08, 7'h55};
    foreach (ops[i])
    begin
      jm.ir(ops[i], r);
      chk("cap", 7'h01, r);
      chk("ir", ops[i], ir_current);
      jm.dr(2, 32'h3, r);
      chk("byp", 2'b10, r);
      chk("hiz", ops[i] == 7'h08, pin_hiz);
      chk("pin", CORE, pin_out);
    end
    $display("t_bypass done");
  endtask
  task automatic t_extest();
    jm.ir(7'h00, r);
    jm.dr(8, 32'ha5, r);
    chk("ext cap", CORE, r);
    chk("ext pin", 8'ha5, pin_out);
    core_out = 8'hc3;
    @(posedge sys_clk);
    #1;
    chk("ext hold", 8'ha5, pin_out);
    jm.ir(7'h04, r);
    chk("clamp pin", 8'ha5, pin_out);
    jm.dr(2, 32'h3, r);
    chk("clamp byp", 2'b10, r);
    jm.ir(7'h01, r);
    jm.dr(8, 32'h5a, r);
    chk("smp cap", 8'hc3, r);
    chk("smp pin", 8'hc3, pin_out);
    core_out = CORE;
    @(posedge sys_clk);
    #1;
    chk("smp follow", CORE, pin_out);
    $display("t_extest done");
  endtask
  task automatic t_fifo();
    int n;
    n = 0;
    smp_valid = 1'b1;
    while (smp_ready === 1'b1 && n < 40)
    begin
      smp_data = n[7:0] + 8'h40;
      @(posedge sys_clk);
      #1;
      n++;
    end
    smp_valid = 1'b0;
    chk("fill", 32, n);
    for (int i = 0; i < 32; i++)
    begin
      jm.dr(8, 32'h0, r);
      chk("word", i[7:0] + 8'h40, r);
    end
    jm.dr(8, 32'h0, r);
    chk("empty cap", CORE, r);
    chk("ready", 1'b1, smp_ready);
    $display("t_fifo done");
  endtask
  task automatic t_trst();
    jm.ir(7'h7f, r);
    jm.walk(4, 8'h03);
    trst_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    chk("trst ir", 7'h02, ir_current);
    chk("trst tlr", 1'b1, test_reset);
    chk("trst oe", 1'b0, tdo_oe);
    trst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    jm.walk(1, 8'h00);
    chk("rti", 1'b0, test_reset);
    jm.ir(7'h08, r);
    jm.walk(6, 8'h1f);
    chk("tms ir", 7'h02, ir_current);
    $display("t_trst done");
  endtask
  initial
  begin
    rst_n = 1'b0;
    trst_n = 1'b1;
    smp_valid = 1'b0;
    smp_data = 8'h00;
    core_out = CORE;
    repeat (8) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    t_reset();
    t_bypass();
    t_extest();
    t_fifo();
    t_trst();
    final_report();
  end
  initial
  begin
    #3000000;
    err_count++;
    final_report();
  end
endmodule
`default_nettype wire
